// ==== hdl/tlic_pkg.sv ====
// package of the two-level interrupt controller: offsets, masks, vectors, types
// assumes 8-bit registers on a 32-bit APB with word-aligned register slots
package tlic_pkg;

  localparam int NSRC = 12;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_EN_PRI = 8'hA8;
  localparam logic [7:0] IDX_EN_SEC = 8'hA9;
  localparam logic [7:0] IDX_PRIO_PRI = 8'hB8;
  localparam logic [7:0] IDX_PRIO_SEC = 8'hB9;
  localparam logic [7:0] IDX_STATUS = 8'hBC;
  localparam logic [11:0] ADDR_EN_PRI = {2'h0, IDX_EN_PRI, 2'h0};
  localparam logic [11:0] ADDR_EN_SEC = {2'h0, IDX_EN_SEC, 2'h0};
  localparam logic [11:0] ADDR_PRIO_PRI = {2'h0, IDX_PRIO_PRI, 2'h0};
  localparam logic [11:0] ADDR_PRIO_SEC = {2'h0, IDX_PRIO_SEC, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  // writable bits; reserved bits ignore writes and read as zero
  localparam logic [7:0] MASK_EN_PRI = 8'hFF;
  localparam logic [7:0] MASK_EN_SEC = 8'h2F;
  localparam logic [7:0] MASK_PRIO_PRI = 8'h7F;
  localparam logic [7:0] MASK_PRIO_SEC = 8'h2F;
  localparam logic [7:0] RST_REG = 8'h00;

  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PRI_ADC_BIT = 6;
  localparam int PRI_T2_BIT = 5;
  localparam int PRI_UART_BIT = 4;
  localparam int PRI_T1_BIT = 3;
  localparam int PRI_EXT1_BIT = 2;
  localparam int PRI_T0_BIT = 1;
  localparam int PRI_EXT0_BIT = 0;
  localparam int SEC_CMP_BIT = 5;
  localparam int SEC_EXT2_BIT = 3;
  localparam int SEC_BTM_BIT = 2;
  localparam int SEC_PWM_BIT = 1;
  localparam int SEC_SSI_BIT = 0;
  localparam int STACK_DEPTH = 2;

  // source index order equals query order: ext0,t0,ext1,t1,uart,t2,adc,ssi,pwm,btm,ext2,cmp
  localparam logic [NSRC-1:0][15:0] VECTORS = {
    16'h0063, 16'h0053, 16'h004B, 16'h0043, 16'h003B, 16'h0033,
    16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

  typedef struct packed {
    logic [7:0] en_pri;
    logic [7:0] en_sec;
    logic [7:0] prio_pri;
    logic [7:0] prio_sec;
    logic hi_act;
    logic lo_act;
    logic [1:0] sp;
    logic [STACK_DEPTH-1:0][15:0] stk;
    logic skip;
    logic pc_load;
    logic [15:0] pc_val;
    logic [NSRC-1:0] ack;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tlic_state_t;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
  } tlic_pick_t;

endpackage : tlic_pkg

// ==== hdl/tlic_ctrl.sv ====
// two-level interrupt controller with return-address stack and APB registers
// assumes flags are level signals on mclk_i held by peripherals until cleared,
// and that the core pulses insn_done_i at each instruction boundary with the
// address of the next instruction on next_pc_i
//
// Operation
// - accept at boundary, push PC, load vector
// - on return, pop PC and resume
// - other requests stay pending during service
// - bit 7 primary enable gates everything
// - primary bit 6 enables ADC
// - primary bit 5 enables Timer2
// - primary bit 4 enables UART
// - primary bit 3 enables Timer1
// - primary bit 2 enables external 1
// - bit 1 Timer0, bit 0 external 0
// - primary enable resets all zero
// - primary priority bits per source, bit7 reserved
// - secondary enables comparator, ext2, base timer
// - secondary bit 1 enables PWM overflow
// - secondary bit 0 enables serial interface
// - secondary priority bits, reserved 7,6,4
// - high preempts low, equal never nests
// - one instruction after return before accepting
// - equal priority: smaller query number first
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module tlic_ctrl (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [tlic_pkg::NSRC-1:0] irq_flag_i,
  input wire logic insn_done_i,
  input wire logic return_from_interrupt_i,
  input wire logic [15:0] next_pc_i,
  output logic pc_load_o,
  output logic [15:0] pc_value_o,
  output logic [tlic_pkg::NSRC-1:0] irq_ack_o
);

  tlic_pkg::tlic_state_t s_q;
  tlic_pkg::tlic_state_t s_d;
  logic [tlic_pkg::NSRC-1:0] en_vec;
  logic [tlic_pkg::NSRC-1:0] prio_vec;
  logic [tlic_pkg::NSRC-1:0] eligible;
  tlic_pkg::tlic_pick_t hi_pick;
  tlic_pkg::tlic_pick_t lo_pick;
  tlic_pkg::tlic_pick_t take;
  logic take_hi;
  logic apb_done;
  logic apb_start;

  // lowest set index wins
  function automatic tlic_pkg::tlic_pick_t pick_lowest(
    input logic [tlic_pkg::NSRC-1:0] v
  );
    tlic_pkg::tlic_pick_t p;
    p.valid = 1'b0;
    p.idx = 4'h0;
    for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        p.valid = 1'b1;
        p.idx = 4'(i);
      end
    end
    return p;
  endfunction : pick_lowest

  // map register bits onto query-ordered source vectors
  assign en_vec = {s_q.en_sec[tlic_pkg::SEC_CMP_BIT],
                   s_q.en_sec[tlic_pkg::SEC_EXT2_BIT],
                   s_q.en_sec[tlic_pkg::SEC_BTM_BIT],
                   s_q.en_sec[tlic_pkg::SEC_PWM_BIT],
                   s_q.en_sec[tlic_pkg::SEC_SSI_BIT],
                   s_q.en_pri[tlic_pkg::PRI_ADC_BIT],
                   s_q.en_pri[tlic_pkg::PRI_T2_BIT],
                   s_q.en_pri[tlic_pkg::PRI_UART_BIT],
                   s_q.en_pri[tlic_pkg::PRI_T1_BIT],
                   s_q.en_pri[tlic_pkg::PRI_EXT1_BIT],
                   s_q.en_pri[tlic_pkg::PRI_T0_BIT],
                   s_q.en_pri[tlic_pkg::PRI_EXT0_BIT]};
  assign prio_vec = {s_q.prio_sec[tlic_pkg::SEC_CMP_BIT],
                     s_q.prio_sec[tlic_pkg::SEC_EXT2_BIT],
                     s_q.prio_sec[tlic_pkg::SEC_BTM_BIT],
                     s_q.prio_sec[tlic_pkg::SEC_PWM_BIT],
                     s_q.prio_sec[tlic_pkg::SEC_SSI_BIT],
                     s_q.prio_pri[6:0]};

  // gating by global enable, source enable and pending flag
  assign eligible = irq_flag_i & en_vec &
                    {tlic_pkg::NSRC{s_q.en_pri[tlic_pkg::GLOBAL_EN_BIT]}};

  // arbitration per level
  assign hi_pick = pick_lowest(eligible & prio_vec);
  assign lo_pick = pick_lowest(eligible & ~prio_vec);

  // high may preempt low; nothing nests at its own level or below
  always_comb begin
    take_hi = 1'b0;
    take = '0;
    if (!s_q.hi_act && hi_pick.valid) begin
      take_hi = 1'b1;
      take = hi_pick;
    end else if (!s_q.hi_act && !s_q.lo_act && lo_pick.valid) begin
      take = lo_pick;
    end
  end

  // apb phases: one wait state, write lands on the completing edge
  assign apb_start = psel_i && penable_i && !s_q.pready;
  assign apb_done = psel_i && penable_i && s_q.pready;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.ack = '0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // register read data and decode error, presented with pready
    if (apb_start) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      if (paddr_i == tlic_pkg::ADDR_EN_PRI) begin
        s_d.prdata[7:0] = s_q.en_pri;
      end else if (paddr_i == tlic_pkg::ADDR_EN_SEC) begin
        s_d.prdata[7:0] = s_q.en_sec;
      end else if (paddr_i == tlic_pkg::ADDR_PRIO_PRI) begin
        s_d.prdata[7:0] = s_q.prio_pri;
      end else if (paddr_i == tlic_pkg::ADDR_PRIO_SEC) begin
        s_d.prdata[7:0] = s_q.prio_sec;
      end else if (paddr_i == tlic_pkg::ADDR_STATUS) begin
        s_d.prdata[15:0] = {eligible[11:0], s_q.sp, s_q.hi_act, s_q.lo_act};
        s_d.pslverr = pwrite_i; // status is read-only
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else if (apb_done) begin
      s_d.prdata = s_q.prdata;
    end

    // register writes, reserved bits dropped
    if (apb_done && pwrite_i) begin
      if (paddr_i == tlic_pkg::ADDR_EN_PRI) begin
        s_d.en_pri = pwdata_i[7:0] & tlic_pkg::MASK_EN_PRI;
      end else if (paddr_i == tlic_pkg::ADDR_EN_SEC) begin
        s_d.en_sec = pwdata_i[7:0] & tlic_pkg::MASK_EN_SEC;
      end else if (paddr_i == tlic_pkg::ADDR_PRIO_PRI) begin
        s_d.prio_pri = pwdata_i[7:0] & tlic_pkg::MASK_PRIO_PRI;
      end else if (paddr_i == tlic_pkg::ADDR_PRIO_SEC) begin
        s_d.prio_sec = pwdata_i[7:0] & tlic_pkg::MASK_PRIO_SEC;
      end
    end

    // return: pop address, close the innermost active level
    if (return_from_interrupt_i && s_q.sp != 2'h0) begin
      s_d.pc_load = 1'b1;
      s_d.pc_val = s_q.stk[s_q.sp[0] ^ 1'b1];
      s_d.sp = 2'(s_q.sp - 2'h1);
      if (s_q.hi_act) begin
        s_d.hi_act = 1'b0;
      end else begin
        s_d.lo_act = 1'b0;
      end
      s_d.skip = 1'b1;
    end else if (insn_done_i && s_q.skip) begin
      s_d.skip = 1'b0;
    end else if (insn_done_i && !return_from_interrupt_i && take.valid) begin
      // accept at the boundary: push return address, jump to vector
      s_d.stk[s_q.sp[0]] = next_pc_i;
      s_d.sp = 2'(s_q.sp + 2'h1);
      s_d.pc_load = 1'b1;
      s_d.pc_val = tlic_pkg::VECTORS[take.idx];
      s_d.ack[take.idx] = 1'b1;
      if (take_hi) begin
        s_d.hi_act = 1'b1;
      end else begin
        s_d.lo_act = 1'b1;
      end
    end
    // unserved flags are not touched and stay pending
  end

  // state register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.en_pri <= tlic_pkg::RST_REG;
      s_q.en_sec <= tlic_pkg::RST_REG;
      s_q.prio_pri <= tlic_pkg::RST_REG;
      s_q.prio_sec <= tlic_pkg::RST_REG;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign pc_load_o = s_q.pc_load;
  assign pc_value_o = s_q.pc_val;
  assign irq_ack_o = s_q.ack;

endmodule : tlic_ctrl

// ==== test/tlic_periph_model.sv ====
// pending-flag model of the peripherals around tlic_ctrl
// assumes the bench raises events; software clearing is folded into acknowledge
`timescale 1ns/10ps
module tlic_periph_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [11:0] raise_i,
  input wire logic [11:0] irq_ack_i,
  output logic [11:0] flag_o
);
  // flags set on event, cleared once accepted
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 12'h000;
    end else begin
      flag_o <= (flag_o & ~irq_ack_i) | raise_i;
    end
  end
endmodule : tlic_periph_model

// ==== test/tlic_ctrl_monitor.sv ====
// port checker of tlic_ctrl
// assumes one clock domain; bound onto every tlic_ctrl
`timescale 1ns/10ps
module tlic_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [tlic_pkg::NSRC-1:0] irq_flag_i,
  input wire logic insn_done_i,
  input wire logic return_from_interrupt_i,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_value_o,
  input wire logic [tlic_pkg::NSRC-1:0] irq_ack_o
);
  logic [15:0] exp_vec;
  logic ret_q;
  logic skip_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // vector of the acknowledged source
  always_comb begin
    exp_vec = 16'h0000;
    for (int i = 0; i < tlic_pkg::NSRC; i++) if (irq_ack_o[i]) exp_vec = tlic_pkg::VECTORS[i];
  end
  // marks the instruction that follows a return
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ret_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      ret_q <= return_from_interrupt_i;
      skip_q <= (ret_q && pc_load_o) || (skip_q && !insn_done_i);
    end
  end
  a_ack_one_hot: assert property (irq_ack_o != 0 |-> $onehot(irq_ack_o) && pc_load_o)
    else $error("ack not one-hot with load");
  a_ack_vector: assert property (irq_ack_o != 0 |-> pc_value_o == exp_vec)
    else $error("wrong vector");
  a_ack_cause: assert property (irq_ack_o != 0 |-> $past(insn_done_i) && !$past(return_from_interrupt_i))
    else $error("ack without boundary");
  a_ack_flag: assert property (irq_ack_o != 0 |-> (irq_ack_o & ~$past(irq_flag_i)) == 0)
    else $error("ack without pending flag");
  a_pc_hold: assert property (!pc_load_o |-> $stable(pc_value_o))
    else $error("pc value moved");
  a_ret_no_ack: assert property (return_from_interrupt_i |=> irq_ack_o == 0)
    else $error("accept on return");
  a_ret_skip: assert property (skip_q && insn_done_i |=> irq_ack_o == 0)
    else $error("accept right after return");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule : tlic_ctrl_monitor

bind tlic_ctrl tlic_ctrl_monitor u_tlic_ctrl_monitor (.mclk_i, .nrst_i, .pready_o, .pslverr_o,
  .irq_flag_i, .insn_done_i, .return_from_interrupt_i, .pc_load_o, .pc_value_o, .irq_ack_o);

// ==== test/tlic_ctrl_tb.sv ====
// self-checking bench of tlic_ctrl: APB registers, accept and return sequences
// assumes tlic_periph_model holds the pending flags
`timescale 1ns/10ps
module tlic_ctrl_tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, insn_done_i = 1'b0, return_from_interrupt_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, pc_load_o;
  logic [15:0] next_pc_i = 16'h0000, pc_value_o;
  logic [11:0] flag, ack, raise = 12'h000;
  logic [11:0] adr [4] = '{tlic_pkg::ADDR_EN_PRI, tlic_pkg::ADDR_EN_SEC,
    tlic_pkg::ADDR_PRIO_PRI, tlic_pkg::ADDR_PRIO_SEC};
  logic [7:0] msk [4] = '{8'hFF, 8'h2F, 8'h7F, 8'h2F};
  int sb [5] = '{0, 1, 2, 3, 5};
  int failures = 0, check_count = 0;
  // clock
  always #10 mclk_i = ~mclk_i;
  tlic_ctrl u_tlic_ctrl (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_flag_i(flag), .insn_done_i, .return_from_interrupt_i, .next_pc_i,
    .pc_load_o, .pc_value_o, .irq_ack_o(ack));
  tlic_periph_model u_tlic_periph_model (.mclk_i, .nrst_i, .raise_i(raise), .irq_ack_i(ack),
    .flag_o(flag));
  task chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // one APB transfer; e is {pslverr, read data}
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    chk(pready_o, 1'b1);
    chk({pslverr_o, (w || pslverr_o) ? 32'h0 : prdata_o}, e);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // raise peripheral events for one cycle
  task up(input logic [11:0] m);
    @(posedge mclk_i);
    raise <= m;
    @(posedge mclk_i);
    raise <= 12'h000;
  endtask : up
  // instruction boundary (r=0) or return (r=1); checks ack, load and pc
  task op(input logic r, input logic [15:0] v, input logic [11:0] ea, input logic [15:0] epc);
    @(posedge mclk_i);
    return_from_interrupt_i <= r;
    insn_done_i <= !r;
    next_pc_i <= v;
    @(posedge mclk_i);
    return_from_interrupt_i <= 1'b0;
    insn_done_i <= 1'b0;
    #1 chk({pc_load_o, ack}, {r || ea != 0, ea});
    if (r || ea != 0) chk(pc_value_o, epc);
  endtask : op
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    wrap_up;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    foreach (adr[k]) apb(0, adr[k], 32'h0, 33'h0);
    foreach (adr[k]) apb(1, adr[k], 32'hFF, 33'h0);
    foreach (adr[k]) apb(0, adr[k], 32'h0, {25'h0, msk[k]});
    apb(0, 12'h000, 32'h0, {1'b1, 32'h0});
    up(12'hFFF);
    apb(1, tlic_pkg::ADDR_EN_PRI, 32'h7F, 33'h0);
    op(0, 16'h0100, 12'h000, 16'h0);
    for (int i = 0; i < 12; i++) begin
      apb(1, tlic_pkg::ADDR_EN_PRI, i < 7 ? 32'h80 | (32'h1 << i) : 32'h80, 33'h0);
      apb(1, tlic_pkg::ADDR_EN_SEC, i < 7 ? 32'h0 : 32'h1 << sb[i - 7], 33'h0);
      op(0, 16'h1000 + i, 12'h1 << i, tlic_pkg::VECTORS[i]);
      op(1, 16'h0, 12'h0, 16'h1000 + i);
      op(0, 16'h2000, 12'h0, 16'h0);
    end
    apb(1, tlic_pkg::ADDR_EN_PRI, 32'hFF, 33'h0);
    apb(1, tlic_pkg::ADDR_EN_SEC, 32'h2F, 33'h0);
    apb(1, tlic_pkg::ADDR_PRIO_PRI, 32'h20, 33'h0);
    apb(1, tlic_pkg::ADDR_PRIO_SEC, 32'h0, 33'h0);
    up(12'h009);
    op(0, 16'h3000, 12'h001, tlic_pkg::VECTORS[0]);
    up(12'h020);
    op(0, 16'h3100, 12'h020, tlic_pkg::VECTORS[5]);
    op(0, 16'h3200, 12'h0, 16'h0);
    apb(0, tlic_pkg::ADDR_STATUS, 32'h0, 33'h0_0000_008B);
    apb(1, tlic_pkg::ADDR_STATUS, 32'h0, {1'b1, 32'h0});
    op(1, 16'h0, 12'h0, 16'h3100);
    op(0, 16'h3300, 12'h0, 16'h0);
    op(0, 16'h3400, 12'h0, 16'h0);
    op(1, 16'h0, 12'h0, 16'h3000);
    op(0, 16'h3500, 12'h0, 16'h0);
    op(0, 16'h3600, 12'h008, tlic_pkg::VECTORS[3]);
    wrap_up;
  end
endmodule : tlic_ctrl_tb
